// *** verilog/dtc_params.svh ***
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ----------------------------------------------------------
// Register map, channel n at n times the stride
// ----------------------------------------------------------
`define DTC_CH_STRIDE 8'h20
`define DTC_OFF_CTRL 5'h00
`define DTC_OFF_INIT 5'h04
`define DTC_OFF_DELAY 5'h08
`define DTC_OFF_WIDTH 5'h0c
`define DTC_OFF_COUNT 5'h10
`define DTC_OFF_STATUS 5'h14
`define DTC_OFF_CMD 5'h18

// ----------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------
`define DTC_CTRL_W 13
`define DTC_CMD_START 0
`define DTC_CMD_RESET 1
`define DTC_RST_WORD 16'h0000

// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define DTC_MCLK_HZ 125000000
`define DTC_EXT_MAX_HZ 10000000
`define DTC_EXT_MIN_CYC (`DTC_MCLK_HZ / `DTC_EXT_MAX_HZ)
`define DTC_INT_DIV 8'h04
`endif

// *** verilog/dtc_pkg.sv ***
package dtc_pkg;
  // Channel phase
  typedef enum logic [2:0] {
    DTC_IDLE, DTC_RUN, DTC_WAIT, DTC_MEAS, DTC_DELAY, DTC_PULSE, DTC_DONE
  } dtc_phase_t;
  // Operating mode, code 0 is the first mode
  typedef enum logic [2:0] {
    DTC_M_GATED_COUNT, DTC_M_PERIOD, DTC_M_WIDTH, DTC_M_ONE_GATED,
    DTC_M_ONE_TRIG, DTC_M_RETRIG, DTC_M_TRIG_CONT, DTC_M_CONT_GATED
  } dtc_mode_t;
  // Control word, mode in the low bits
  typedef struct packed {
    logic sw_dir;
    logic sw_gate;
    logic sw_clk;
    logic out_pol;
    logic gate_pol;
    logic clk_pol;
    logic dir_sel;
    logic gate_sel;
    logic [1:0] clk_src;
    dtc_mode_t mode;
  } dtc_cfg_t;
  // Per-channel state
  typedef struct packed {
    dtc_cfg_t cfg;
    logic [15:0] init;
    logic [15:0] dly;
    logic [15:0] wid;
    logic [15:0] cnt;
    dtc_phase_t phase;
    logic done;
    logic act;
    logic pin;
    logic clk_s1;
    logic clk_s2;
    logic gate_s1;
    logic gate_s2;
    logic dir_s1;
    logic dir_s2;
    logic clk_prev;
    logic gate_prev;
  } dtc_ch_t;
  // Whole block state
  typedef struct packed {
    dtc_ch_t [1:0] ch;
    logic [7:0] pre;
    logic [31:0] rd;
  } dtc_state_t;
endpackage

// *** verilog/dtc_timer.sv ***
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "dtc_params.svh"
module dtc_timer import dtc_pkg::*; #(
  parameter logic [7:0] INT_DIV = `DTC_INT_DIV // Internal timebase divider
) (
  input wire logic MCLK, // System clock
  input wire logic RST_N, // Synchronous reset, active low
  input wire logic CE, // Clock enable, freezes all state
  input wire logic [7:0] ADDR, // Register byte address
  input wire logic [31:0] WR_DATA, // Write data
  input wire logic WR_STB, // Write strobe
  input wire logic RD_STB, // Read strobe
  output logic [31:0] RD_DATA, // Read data, cycle after strobe
  input wire logic [1:0] COUNT_CLOCK_IN, // Count clock pins
  input wire logic [1:0] COUNT_GATE_IN, // Gate pins
  input wire logic [1:0] COUNT_DIRECTION_IN, // Direction pins, high counts up
  output logic [1:0] COUNTER_OUTPUT // Channel outputs
);

  // ----------------------------------------------------------
  // State and per-channel helper levels
  // ----------------------------------------------------------
  localparam logic [1:0] SRC_INT = 2'h0; // Internal timebase
  localparam logic [1:0] SRC_PIN = 2'h1; // External pin
  dtc_state_t r; // Registered state
  dtc_state_t n; // Next state
  logic tick_int; // Internal timebase strobe
  logic [1:0] tick; // Active count clock edge
  logic [1:0] gact; // Gate at its active level
  logic [1:0] gedge; // Gate became active
  logic [1:0] gfall; // Gate became inactive
  logic [1:0] up; // Direction level
  logic [1:0] en; // Counting allowed by gate
  logic [1:0] hit; // Channel addressed
  logic [1:0] clv; // Selected clock level, polarity applied

  // ----------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------
  // All channels are updated in one pass so bus writes and
  // counting resolve in a single, fixed priority
  always_comb begin
    n = r;
    n.rd = 32'h0;
    tick = 2'h0;
    gact = 2'h0;
    gedge = 2'h0;
    gfall = 2'h0;
    up = 2'h0;
    en = 2'h0;
    hit = 2'h0;
    clv = 2'h0;
    // Free running internal timebase
    tick_int = (r.pre == INT_DIV - 8'h01);
    n.pre = tick_int ? 8'h00 : r.pre + 8'h01;
    for (int i = 0; i < 2; i++) begin
      // Two-flop synchronisers; only stage two is looked at
      n.ch[i].clk_s1 = COUNT_CLOCK_IN[i];
      n.ch[i].clk_s2 = r.ch[i].clk_s1;
      n.ch[i].gate_s1 = COUNT_GATE_IN[i];
      n.ch[i].gate_s2 = r.ch[i].gate_s1;
      n.ch[i].dir_s1 = COUNT_DIRECTION_IN[i];
      n.ch[i].dir_s2 = r.ch[i].dir_s1;
      // Clock source, pin rate limited by the synchroniser
      if (r.ch[i].cfg.clk_src == SRC_PIN) begin
        clv[i] = r.ch[i].clk_s2 ^ r.ch[i].cfg.clk_pol;
      end else begin
        clv[i] = r.ch[i].cfg.sw_clk ^ r.ch[i].cfg.clk_pol;
      end
      n.ch[i].clk_prev = clv[i];
      if (r.ch[i].cfg.clk_src == SRC_INT) begin
        tick[i] = tick_int;
      end else begin
        tick[i] = clv[i] & ~r.ch[i].clk_prev;
      end
      // Gate from pin or software, then polarity
      gact[i] = (r.ch[i].cfg.gate_sel ? r.ch[i].cfg.sw_gate : r.ch[i].gate_s2)
                ^ r.ch[i].cfg.gate_pol;
      n.ch[i].gate_prev = gact[i];
      gedge[i] = gact[i] & ~r.ch[i].gate_prev;
      gfall[i] = ~gact[i] & r.ch[i].gate_prev;
      up[i] = r.ch[i].cfg.dir_sel ? r.ch[i].cfg.sw_dir : r.ch[i].dir_s2;
      // Gated pulse modes pause while the gate is inactive
      if (r.ch[i].cfg.mode == DTC_M_ONE_GATED || r.ch[i].cfg.mode == DTC_M_CONT_GATED) begin
        en[i] = gact[i];
      end else begin
        en[i] = 1'b1;
      end
      // Mode sequencing
      case (r.ch[i].phase)
        DTC_IDLE: begin
          // Halted until start
        end
        DTC_RUN: begin
          // Gated event counting
          if (tick[i] && gact[i]) begin
            n.ch[i].cnt = up[i] ? r.ch[i].cnt + 16'h1 : r.ch[i].cnt - 16'h1;
          end
        end
        DTC_WAIT: begin
          // Waiting for an active gate edge
          if (gedge[i]) begin
            case (r.ch[i].cfg.mode)
              DTC_M_PERIOD, DTC_M_WIDTH: begin
                n.ch[i].phase = DTC_MEAS;
              end
              DTC_M_ONE_TRIG, DTC_M_RETRIG, DTC_M_TRIG_CONT: begin
                n.ch[i].phase = DTC_DELAY;
                n.ch[i].cnt = r.ch[i].dly;
              end
              default: begin
                n.ch[i].phase = DTC_WAIT;
              end
            endcase
          end
        end
        DTC_MEAS: begin
          // Period counts every edge, width only while gate is active
          if (tick[i] && (r.ch[i].cfg.mode == DTC_M_PERIOD || gact[i])) begin
            n.ch[i].cnt = up[i] ? r.ch[i].cnt + 16'h1 : r.ch[i].cnt - 16'h1;
          end
          if ((r.ch[i].cfg.mode == DTC_M_PERIOD && gedge[i]) ||
              (r.ch[i].cfg.mode == DTC_M_WIDTH && gfall[i])) begin
            n.ch[i].phase = DTC_DONE;
            n.ch[i].done = 1'b1;
            n.ch[i].act = 1'b1;
          end
        end
        DTC_DELAY: begin
          // A delay of zero acts as one period
          if (tick[i] && en[i]) begin
            if (r.ch[i].cnt <= 16'h1) begin
              n.ch[i].phase = DTC_PULSE;
              n.ch[i].cnt = r.ch[i].wid;
              n.ch[i].act = 1'b1;
            end else begin
              n.ch[i].cnt = r.ch[i].cnt - 16'h1;
            end
          end
        end
        DTC_PULSE: begin
          // Gate edges here are ignored by construction
          if (tick[i] && en[i]) begin
            if (r.ch[i].cnt <= 16'h1) begin
              n.ch[i].act = 1'b0;
              case (r.ch[i].cfg.mode)
                DTC_M_RETRIG: begin
                  n.ch[i].phase = DTC_WAIT;
                end
                DTC_M_TRIG_CONT, DTC_M_CONT_GATED: begin
                  n.ch[i].phase = DTC_DELAY;
                  n.ch[i].cnt = r.ch[i].dly;
                end
                default: begin
                  n.ch[i].phase = DTC_DONE;
                  n.ch[i].done = 1'b1;
                end
              endcase
            end else begin
              n.ch[i].cnt = r.ch[i].cnt - 16'h1;
            end
          end
        end
        DTC_DONE: begin
          // Result held until software acts
        end
        default: begin
          n.ch[i].phase = DTC_IDLE;
        end
      endcase
      // Register writes; a start command restarts the channel outright
      hit[i] = (ADDR[7:6] == 2'h0) && (ADDR[5] == 1'(i));
      if (WR_STB && hit[i]) begin
        case (ADDR[4:0])
          `DTC_OFF_CTRL: begin
            n.ch[i].cfg = dtc_cfg_t'(WR_DATA[`DTC_CTRL_W-1:0]);
          end
          `DTC_OFF_INIT: begin
            n.ch[i].init = WR_DATA[15:0];
          end
          `DTC_OFF_DELAY: begin
            n.ch[i].dly = WR_DATA[15:0];
          end
          `DTC_OFF_WIDTH: begin
            n.ch[i].wid = WR_DATA[15:0];
          end
          `DTC_OFF_CMD: begin
            if (WR_DATA[`DTC_CMD_RESET]) begin
              n.ch[i].phase = DTC_IDLE;
              n.ch[i].cnt = r.ch[i].init;
              n.ch[i].done = 1'b0;
              n.ch[i].act = 1'b0;
            end else if (WR_DATA[`DTC_CMD_START]) begin
              n.ch[i].done = 1'b0;
              n.ch[i].act = 1'b0;
              n.ch[i].cnt = r.ch[i].init;
              case (r.ch[i].cfg.mode)
                DTC_M_GATED_COUNT: begin
                  n.ch[i].phase = DTC_RUN;
                end
                DTC_M_ONE_GATED, DTC_M_CONT_GATED: begin
                  n.ch[i].phase = DTC_DELAY;
                  n.ch[i].cnt = r.ch[i].dly;
                end
                default: begin
                  n.ch[i].phase = DTC_WAIT;
                end
              endcase
            end
          end
          default: begin
            // Read-only or unmapped, ignored
          end
        endcase
      end
      // Output level after polarity, low from reset onward
      n.ch[i].pin = n.ch[i].act ^ n.ch[i].cfg.out_pol;
    end
    // Read port; count read has no side effect
    if (RD_STB && ADDR[7:6] == 2'h0) begin
      case (ADDR[4:0])
        `DTC_OFF_CTRL: begin
          n.rd = {19'h0, r.ch[ADDR[5]].cfg};
        end
        `DTC_OFF_INIT: begin
          n.rd = {16'h0, r.ch[ADDR[5]].init};
        end
        `DTC_OFF_DELAY: begin
          n.rd = {16'h0, r.ch[ADDR[5]].dly};
        end
        `DTC_OFF_WIDTH: begin
          n.rd = {16'h0, r.ch[ADDR[5]].wid};
        end
        `DTC_OFF_COUNT: begin
          n.rd = {16'h0, r.ch[ADDR[5]].cnt};
        end
        `DTC_OFF_STATUS: begin
          n.rd = {26'h0, r.ch[ADDR[5]].pin, r.ch[ADDR[5]].done,
                  r.ch[ADDR[5]].act, r.ch[ADDR[5]].phase};
        end
        default: begin
          n.rd = 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  // Whole state clears to zero: idle, output low, count zero
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      r <= '0;
    end else if (CE) begin
      r <= n;
    end
  end

  assign RD_DATA = r.rd;
  assign COUNTER_OUTPUT = {r.ch[1].pin, r.ch[0].pin};

  // ----------------------------------------------------------
  // Assertions, commands on channel 0, pulse modes on channel 1
  // ----------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // Command decode for channel 0, kept as plain levels so that
  // they can be combined freely with other conditions
  logic cmd0; // Command register of channel 0 written
  logic start0; // Start alone on channel 0
  logic reset0; // Software reset on channel 0
  assign cmd0 = CE && WR_STB && ADDR == {3'h0, `DTC_OFF_CMD};
  assign start0 = cmd0 && WR_DATA[`DTC_CMD_START] && !WR_DATA[`DTC_CMD_RESET];
  assign reset0 = cmd0 && WR_DATA[`DTC_CMD_RESET];

  // Start taken on channel 0
  sequence s_start0;
    start0;
  endsequence
  // Reloaded and idle, and still idle a cycle on unless restarted
  sequence s_reloaded0;
    r.ch[0].phase == DTC_IDLE && r.ch[0].cnt == $past(r.ch[0].init) && !r.ch[0].done
      ##1 (r.ch[0].phase == DTC_IDLE || $past(start0));
  endsequence
  // Measurement finished: flag set, output at its active level
  sequence s_result0;
    r.ch[0].done && COUNTER_OUTPUT[0] == !r.ch[0].cfg.out_pol;
  endsequence

  property p_init_low;
    $rose(RST_N) |-> COUNTER_OUTPUT == 2'h0;
  endproperty
  a_init_low: assert property (p_init_low)
    else $error("output not low after reset");

  property p_count_read;
    CE && RD_STB && ADDR == {3'h0, `DTC_OFF_COUNT} |=> RD_DATA == {16'h0, $past(r.ch[0].cnt)};
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count read wrong");

  property p_halt;
    r.ch[0].phase == DTC_IDLE && !start0 |=> r.ch[0].phase == DTC_IDLE;
  endproperty
  a_halt: assert property (p_halt)
    else $error("channel ran without start");

  property p_start;
    s_start0 |=> r.ch[0].phase != DTC_IDLE && !r.ch[0].done;
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");

  property p_swreset;
    reset0 |=> s_reloaded0;
  endproperty
  a_swreset: assert property (p_swreset)
    else $error("software reset wrong");

  property p_step;
    CE && !WR_STB && r.ch[0].phase == DTC_RUN && tick[0] && gact[0] && up[0]
      |=> r.ch[0].cnt == $past(r.ch[0].cnt) + 16'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step up");

  property p_gate_hold;
    r.ch[0].phase == DTC_RUN && !gact[0] && !WR_STB |=> $stable(r.ch[0].cnt);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("count moved with gate inactive");

  property p_period_done;
    CE && !WR_STB && r.ch[0].phase == DTC_MEAS && r.ch[0].cfg.mode == DTC_M_PERIOD
      && gedge[0] |=> s_result0;
  endproperty
  a_period_done: assert property (p_period_done)
    else $error("period end not flagged");

  property p_width_done;
    CE && !WR_STB && r.ch[0].phase == DTC_MEAS && r.ch[0].cfg.mode == DTC_M_WIDTH
      && gfall[0] |=> s_result0;
  endproperty
  a_width_done: assert property (p_width_done)
    else $error("pulse width end not flagged");

  property p_pause;
    r.ch[1].cfg.mode == DTC_M_ONE_GATED && r.ch[1].phase == DTC_DELAY && !gact[1]
      && !WR_STB |=> $stable(r.ch[1].cnt);
  endproperty
  a_pause: assert property (p_pause)
    else $error("gated delay moved");

  property p_one_shot;
    r.ch[1].cfg.mode == DTC_M_ONE_TRIG && r.ch[1].phase == DTC_DONE && !WR_STB
      |=> r.ch[1].phase == DTC_DONE;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("single pulse retriggered");

  // A retrigger would reload the delay; a pulse only ever ends in wait
  property p_retrig;
    CE && !WR_STB && r.ch[1].cfg.mode == DTC_M_RETRIG && r.ch[1].phase == DTC_PULSE
      && gedge[1] |=> r.ch[1].phase != DTC_DELAY;
  endproperty
  a_retrig: assert property (p_retrig)
    else $error("gate edge restarted a running pulse");

  property p_cont_pause;
    r.ch[1].cfg.mode == DTC_M_CONT_GATED && !gact[1] && !WR_STB
      && (r.ch[1].phase == DTC_DELAY || r.ch[1].phase == DTC_PULSE)
      |=> $stable(r.ch[1].cnt) && $stable(r.ch[1].phase);
  endproperty
  a_cont_pause: assert property (p_cont_pause)
    else $error("continuous pulses moved with gate inactive");

endmodule

// *** test/dtc_src_model.sv ***
`timescale 1ns/1ns
module dtc_src_model (
  input wire logic mclk, // Pacing clock
  output logic [1:0] count_clock_in, // Count clocks
  output logic [1:0] count_gate_in, // Gates
  output logic [1:0] count_direction_in // Direction, high is up
);
  // ------------------------------
  // Idle levels
  // ------------------------------
  // Clocks stand low between bursts
  initial begin
    count_clock_in = 2'h0;
    count_gate_in = 2'h0;
    count_direction_in = 2'h3;
  end

  // ------------------------------
  // Source tasks
  // ------------------------------
  // Gate level, changed just after an edge
  task automatic set_gate(input int ch, input logic lvl);
    @(posedge mclk);
    count_gate_in[ch] <= lvl;
  endtask
  // Three cycle gate pulse, long enough for the synchroniser
  task automatic gate_pulse(input int ch);
    set_gate(ch, 1'b1);
    repeat (2) @(posedge mclk);
    set_gate(ch, 1'b0);
  endtask
  // Thirteen cycle period keeps the rate just under the limit
  task automatic clk_burst(input int ch, input int n);
    repeat (n) begin
      @(posedge mclk);
      count_clock_in[ch] <= 1'b1;
      repeat (6) @(posedge mclk);
      count_clock_in[ch] <= 1'b0;
      repeat (6) @(posedge mclk);
    end
  endtask
endmodule

// *** test/dtc_timer_tb.sv ***
`timescale 1ns/1ns
module dtc_timer_tb import dtc_pkg::*;;
  // ------------------------------
  // Signals
  // ------------------------------
  logic mclk; // Clock
  logic rst_n; // Reset, active low
  logic [7:0] addr; // Address
  logic [31:0] wdat; // Write data
  logic wstb; // Write strobe
  logic rstb; // Read strobe
  logic ce; // Clock enable
  logic [31:0] rdat; // Read data
  logic [1:0] cpin; // Clock pins
  logic [1:0] gpin; // Gate pins
  logic [1:0] dpin; // Direction pins
  logic [1:0] q; // Channel outputs
  int errors; // Mismatches
  int samples_checked; // Comparisons
  logic [31:0] rd; // Last read value
  dtc_cfg_t cfg; // Control word
  int hi; // High cycles in a window
  int rises; // Rising edges in a window
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dtc_row_t;
  typedef struct {dtc_mode_t m; logic hold; logic [31:0] e;} dtc_prow_t;
  // Write then read back; read-only places and holes give 0
  dtc_row_t rows [11] = '{'{8'h04, 32'h1234abcd, 32'h0000abcd},
    '{8'h08, 32'hffff, 32'hffff}, '{8'h0c, 32'h0001, 32'h0001},
    '{8'h00, 32'hffff, 32'h1fff}, '{8'h00, 32'h0, 32'h0},
    '{8'h24, 32'h5a5a, 32'h5a5a}, '{8'h2c, 32'h00a5, 32'h00a5},
    '{8'h10, 32'hffff, 32'h0}, '{8'h14, 32'hffff, 32'h0},
    '{8'h1c, 32'hffff, 32'h0}, '{8'h40, 32'hffff, 32'h0}};
  // Single pulse modes: delay 2, width 4, tick every 4 cycles
  dtc_prow_t prow [3] = '{'{DTC_M_ONE_GATED, 1'b1, 32'd16},
    '{DTC_M_ONE_TRIG, 1'b0, 32'd16}, '{DTC_M_RETRIG, 1'b0, 32'd32}};

  // ------------------------------
  // Design and far side
  // ------------------------------
  dtc_timer u_dut (.MCLK(mclk), .RST_N(rst_n), .CE(ce),
    .ADDR(addr), .WR_DATA(wdat), .WR_STB(wstb), .RD_STB(rstb), .RD_DATA(rdat),
    .COUNT_CLOCK_IN(cpin), .COUNT_GATE_IN(gpin), .COUNT_DIRECTION_IN(dpin),
    .COUNTER_OUTPUT(q));
  dtc_src_model u_src (.mclk(mclk), .count_clock_in(cpin), .count_gate_in(gpin),
    .count_direction_in(dpin));

  // Free running 8 ns clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, seen);
    end
  endtask
  // One cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdat <= d;
    wstb <= 1'b1;
    @(posedge mclk);
    wstb <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input string n, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge mclk);
    rstb <= 1'b0;
    #1 rd = rdat;
    check(n, rd, e);
  endtask
  // Software bits bypass the synchroniser; six idle cycles still follow each write
  task automatic setcfg(input logic [7:0] b);
    wr(b, {19'h0, cfg});
    repeat (6) @(posedge mclk);
  endtask
  task automatic swclk(input int n);
    repeat (n) begin
      cfg.sw_clk = 1'b1;
      setcfg(8'h00);
      cfg.sw_clk = 1'b0;
      setcfg(8'h00);
    end
  endtask
  // Count high cycles and rising edges of one output
  task automatic watch(input int ch, input int n);
    logic prev;
    hi = 0;
    rises = 0;
    prev = q[ch];
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (q[ch] === 1'b1) hi++;
      if (q[ch] === 1'b1 && prev === 1'b0) rises++;
      prev = q[ch];
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    report_and_stop();
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdat = 32'h0;
    wstb = 1'b0;
    rstb = 1'b0;
    ce = 1'b1;
    repeat (15) @(posedge mclk);
    #1 check("out in reset", {30'h0, q}, 32'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, "register", rows[i].e);
    end
    check("out after init", {30'h0, q}, 32'h0);
    // Mode 1, all inputs from software, count down from 5
    cfg = '0;
    cfg.clk_src = 2'h2;
    cfg.gate_sel = 1'b1;
    cfg.dir_sel = 1'b1;
    cfg.sw_gate = 1'b1;
    wr(8'h04, 32'h5);
    setcfg(8'h00);
    swclk(2);
    rdchk(8'h10, "count before start", 32'h0);
    wr(8'h18, 32'h1);
    swclk(3);
    rdchk(8'h10, "count down", 32'h2);
    cfg.gate_pol = 1'b1;
    swclk(2);
    rdchk(8'h10, "gate closed", 32'h2);
    cfg.gate_pol = 1'b0;
    cfg.sw_dir = 1'b1;
    swclk(4);
    rdchk(8'h10, "count up", 32'h6);
    rdchk(8'h10, "reread", 32'h6);
    // Pin edges are lost while the enable is low, counted once it is high
    cfg.clk_src = 2'h1;
    setcfg(8'h00);
    ce <= 1'b0;
    u_src.clk_burst(0, 3);
    ce <= 1'b1;
    rdchk(8'h10, "frozen by enable", 32'h6);
    u_src.clk_burst(0, 2);
    rdchk(8'h10, "pin clock up", 32'h8);
    cfg.clk_src = 2'h2;
    wr(8'h18, 32'h2);
    swclk(2);
    rdchk(8'h10, "reload, halted", 32'h5);
    rdchk(8'h14, "status cleared", 32'h0);
    // Mode 3, pin clock, 5 clocks inside the gate pulse
    cfg = '0;
    cfg.clk_src = 2'h1;
    cfg.mode = DTC_M_WIDTH;
    wr(8'h04, 32'h0);
    setcfg(8'h00);
    wr(8'h18, 32'h1);
    u_src.set_gate(0, 1'b1);
    repeat (8) @(posedge mclk);
    u_src.clk_burst(0, 5);
    u_src.set_gate(0, 1'b0);
    u_src.clk_burst(0, 2);
    #1 check("width done", {31'h0, q[0]}, 32'h1);
    rdchk(8'h10, "width", 32'h5);
    // Mode 2, 7 clocks between two gate edges
    cfg.mode = DTC_M_PERIOD;
    setcfg(8'h00);
    wr(8'h18, 32'h1);
    u_src.gate_pulse(0);
    repeat (4) @(posedge mclk);
    u_src.clk_burst(0, 7);
    u_src.gate_pulse(0);
    repeat (10) @(posedge mclk);
    #1 check("period done", {31'h0, q[0]}, 32'h1);
    rdchk(8'h10, "period", 32'h7);
    // Single pulse modes on channel 1 from the gate pin
    foreach (prow[i]) begin
      cfg = '0;
      cfg.mode = prow[i].m;
      setcfg(8'h20);
      wr(8'h28, 32'h2);
      wr(8'h2c, 32'h4);
      u_src.set_gate(1, prow[i].hold);
      wr(8'h38, 32'h1);
      fork
        watch(1, 300);
        if (!prow[i].hold) begin
          u_src.gate_pulse(1);
          repeat (10) @(posedge mclk);
          u_src.gate_pulse(1);
          repeat (140) @(posedge mclk);
          u_src.gate_pulse(1);
        end
      join
      check("pulse cycles", 32'(hi), prow[i].e);
      u_src.set_gate(1, 1'b0);
    end
    // Mode 4 with the gate closed: the delay must wait for the gate
    cfg.mode = DTC_M_ONE_GATED;
    setcfg(8'h20);
    wr(8'h38, 32'h1);
    watch(1, 100);
    check("gate closed, no pulse", 32'(hi), 32'h0);
    rdchk(8'h30, "delay held", 32'h2);
    u_src.set_gate(1, 1'b1);
    watch(1, 100);
    check("gate open, pulse", 32'(hi), 32'd16);
    u_src.set_gate(1, 1'b0);
    // Mode 7, endless after one edge, then halted by reset
    cfg.mode = DTC_M_TRIG_CONT;
    setcfg(8'h20);
    wr(8'h28, 32'h4);
    wr(8'h2c, 32'h3);
    wr(8'h38, 32'h1);
    fork
      watch(1, 300);
      u_src.gate_pulse(1);
    join
    check("endless pulses", 32'(rises >= 3), 32'h1);
    wr(8'h38, 32'h2);
    repeat (4) @(posedge mclk);
    u_src.gate_pulse(1);
    watch(1, 200);
    check("halted", 32'(hi), 32'h0);
    // Mode 8, runs with the gate open, freezes when closed
    cfg.mode = DTC_M_CONT_GATED;
    setcfg(8'h20);
    u_src.set_gate(1, 1'b1);
    wr(8'h38, 32'h1);
    watch(1, 300);
    check("gated pulses", 32'(rises >= 3), 32'h1);
    u_src.set_gate(1, 1'b0);
    repeat (10) @(posedge mclk);
    watch(1, 200);
    check("gated freeze", 32'(rises), 32'h0);
    // Output polarity inverts the idle level
    cfg = '0;
    cfg.out_pol = 1'b1;
    setcfg(8'h00);
    wr(8'h18, 32'h2);
    repeat (4) @(posedge mclk);
    #1 check("inverted idle", {31'h0, q[0]}, 32'h1);
    report_and_stop();
  end
endmodule
